// file: rtl/pscfg_consts.vh
/*
 * constants for the port strap configuration and interrupt block:
 * register offsets, field positions and reset values.
 * assumes a 40 MHz system clock and a byte-addressed Avalon-MM slave.
 */
`ifndef PSCFG_CONSTS_VH
`define PSCFG_CONSTS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PSCFG_ADDR_W 8
`define PSCFG_OFS_STRAP 8'h00
`define PSCFG_OFS_CFG 8'h04
`define PSCFG_OFS_ANRES 8'h08
`define PSCFG_OFS_IRQ_STAT 8'hBB
`define PSCFG_OFS_IRQ_MASK 8'hBC
`define PSCFG_IDX_IRQ_STAT 8'hBB
`define PSCFG_IDX_IRQ_MASK 8'hBC

// ----------------------------------------
// strap vector bit positions
// ----------------------------------------
`define PSCFG_S_PORT1_DUPLEX_STRAP 0
`define PSCFG_S_P2AN 1
`define PSCFG_S_PORT2_SPEED_STRAP 2
`define PSCFG_S_PORT2_DUPLEX_STRAP 3
`define PSCFG_S_P2FC 4
`define PSCFG_S_P1FC 5
`define PSCFG_S_P1AN 6
`define PSCFG_S_PORT1_SPEED_STRAP 7
`define PSCFG_NSTRAP 8

// ----------------------------------------
// resolved config per port (4 bits each)
// ----------------------------------------
`define PSCFG_C_AN 0
`define PSCFG_C_SPD 1
`define PSCFG_C_DPX 2
`define PSCFG_C_FC 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define PSCFG_MASK_RST 2'h0
`define PSCFG_STAT_RST 2'h0

`endif

// file: rtl/pscfg_top.v
/*
 * strap-in configuration for switch ports 1 and 2, plus the active-low
 * host interrupt raised on link loss.
 * assumes strap pins are held stable by board resistors during reset,
 * one 40 MHz clock, and an Avalon-MM master for the register access.
 */
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "pscfg_consts.vh"

module pscfg_top
(
  input wire clk,
  input wire nrst,
  input wire ce,
  // strap pins, raw from the pads
  input wire port3_rx_valid_in,
  input wire port3_rx_bit3_in,
  input wire port3_rx_bit2_in,
  input wire port3_rx_bit1_in,
  input wire port3_rx_bit0_in,
  input wire serial_data_in_pin,
  input wire port1_led_a_in,
  input wire port1_led_b_in,
  // functional values the core wants on the shared pins
  input wire [7:0] func_pin_out,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe,
  // autoneg outcome per port, from the phy logic (same clock)
  input wire [1:0] an_done,
  input wire [1:0] an_ok,
  input wire [1:0] an_speed100,
  input wire [1:0] an_full,
  input wire [1:0] an_pause,
  input wire [1:0] link_up,
  // resolved per-port configuration
  output reg [1:0] cfg_an_en,
  output reg [1:0] cfg_speed100,
  output reg [1:0] cfg_full,
  output reg [1:0] cfg_fc_en,
  output wire cfg_valid,
  // avalon-mm slave
  input wire [`PSCFG_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire host_irq_n
);

  // ----------------------------------------
  // strap sampling
  // ----------------------------------------
  wire [`PSCFG_NSTRAP-1:0] pad_raw;
  reg [`PSCFG_NSTRAP-1:0] sync1_r;
  reg [`PSCFG_NSTRAP-1:0] sync2_r;
  reg [`PSCFG_NSTRAP-1:0] strap_r;
  reg [1:0] rst_sync_r;
  reg latched_r;

  assign pad_raw = {port1_led_b_in, port1_led_a_in, serial_data_in_pin,
                    port3_rx_bit0_in, port3_rx_bit1_in, port3_rx_bit2_in,
                    port3_rx_bit3_in, port3_rx_valid_in};

  // the synchroniser runs through reset so the pad level is known at release
  always @(posedge clk)
  begin
    if (ce)
    begin
      sync1_r <= pad_raw;
      sync2_r <= sync1_r;
    end
  end

  // release edge: rst_sync_r fills with ones two edges after nrst rises
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_r <= 2'h0;
    else if (ce)
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // capture once at release; pins stay undriven until then
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_r <= 8'h00;
      latched_r <= 1'b0;
    end
    else if (ce && rst_sync_r[1] && !latched_r)
    begin
      strap_r <= sync2_r;
      latched_r <= 1'b1;
    end
  end

  assign cfg_valid = latched_r;

  // output enables held low until straps are captured, so pulls are not fought
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
    end
    else if (ce)
    begin
      pin_out <= func_pin_out;
      pin_oe <= {8{latched_r}};
    end
  end

  // ----------------------------------------
  // per-port resolution
  // ----------------------------------------
  wire [1:0] s_an;
  wire [1:0] s_spd;
  wire [1:0] s_dpx;
  wire [1:0] s_fc;

  assign s_an = {strap_r[`PSCFG_S_P2AN], strap_r[`PSCFG_S_P1AN]};
  assign s_spd = {strap_r[`PSCFG_S_PORT2_SPEED_STRAP], strap_r[`PSCFG_S_PORT1_SPEED_STRAP]};
  assign s_dpx = {strap_r[`PSCFG_S_PORT2_DUPLEX_STRAP], strap_r[`PSCFG_S_PORT1_DUPLEX_STRAP]};
  assign s_fc = {strap_r[`PSCFG_S_P2FC], strap_r[`PSCFG_S_P1FC]};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_port
      wire neg_ok;
      wire spd_nxt;
      wire full_nxt;
      wire fc_nxt;
      assign neg_ok = s_an[g] & an_done[g] & an_ok[g];
      // forced speed when autoneg off; negotiated speed when negotiation succeeded, else speed100 low
      assign spd_nxt = s_an[g] ? (neg_ok ? an_speed100[g] : 1'b0)
                               : s_spd[g];
      // failed or disabled negotiation falls to the duplex strap
      assign full_nxt = neg_ok ? an_full[g] : s_dpx[g];
      // forced on by strap, else whatever negotiation agreed
      assign fc_nxt = s_fc[g] | (neg_ok & an_pause[g]);

      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          cfg_an_en[g] <= 1'b0;
          cfg_speed100[g] <= 1'b0;
          cfg_full[g] <= 1'b0;
          cfg_fc_en[g] <= 1'b0;
        end
        else if (ce && latched_r)
        begin
          cfg_an_en[g] <= s_an[g];
          cfg_speed100[g] <= spd_nxt;
          cfg_full[g] <= full_nxt;
          cfg_fc_en[g] <= fc_nxt;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // link-loss interrupt
  // ----------------------------------------
  reg [1:0] link_d_r;
  reg [1:0] stat_r;
  reg [1:0] mask_r;
  wire [1:0] link_lost;
  wire acc;
  wire wr_stat;
  wire wr_mask;

  // only a fall seen after a valid config counts, so start-up is quiet
  assign link_lost = link_d_r & ~link_up & {2{latched_r}};
  assign acc = avs_read | avs_write;
  assign wr_stat = avs_write && (avs_address == `PSCFG_OFS_IRQ_STAT);
  assign wr_mask = avs_write && (avs_address == `PSCFG_OFS_IRQ_MASK);

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      link_d_r <= 2'h0;
      stat_r <= `PSCFG_STAT_RST;
      mask_r <= `PSCFG_MASK_RST;
    end
    else if (ce)
    begin
      link_d_r <= link_up;
      // a new event beats a write-one-to-clear in the same cycle
      stat_r <= (stat_r & ~(wr_stat ? avs_writedata[1:0] : 2'h0)) | link_lost;
      if (wr_mask)
        mask_r <= avs_writedata[1:0];
    end
  end

  // mask bit one enables that port's interrupt
  assign host_irq_n = ~|(stat_r & mask_r);

  // ----------------------------------------
  // avalon-mm slave
  // ----------------------------------------
  // one wait cycle per access; readdata is a flop, ready on the release edge
  reg ack_r;

  assign avs_waitrequest = acc & ~ack_r;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else if (ce)
    begin
      ack_r <= acc & ~ack_r;
      if (avs_read && !ack_r)
      begin
        case (avs_address)
          `PSCFG_OFS_STRAP: avs_readdata <= {23'h000000, latched_r, strap_r};
          `PSCFG_OFS_CFG: avs_readdata <= {24'h000000, cfg_fc_en, cfg_full,
                                           cfg_speed100, cfg_an_en};
          `PSCFG_OFS_ANRES: avs_readdata <= {22'h000000, link_up, an_ok,
                                             an_done, an_full, an_pause};
          `PSCFG_OFS_IRQ_STAT: avs_readdata <= {30'h00000000, stat_r};
          `PSCFG_OFS_IRQ_MASK: avs_readdata <= {30'h00000000, mask_r};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// file: verification/pscfg_board.sv
/* board side of pscfg_top: strap resistors and the host irq pull-up.
   assumes the bench sets strap levels before reset. */
`timescale 1ns/10ps
module pscfg_board
(
  input wire [7:0] strap,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire host_irq_n,
  output wire [7:0] pad,
  output wire irq_seen_n
);
  // resistor level shows whenever the pin is released
  assign pad = (pin_oe & pin_out) | (~pin_oe & strap);
  assign irq_seen_n = (host_irq_n === 1'b0) ? 1'b0 : 1'b1;
endmodule

// file: verification/pscfg_top_assertions.sv
/* port checks for pscfg_top.
   assumes ce is held high by the bench. */
`timescale 1ns/10ps
module pscfg_chk
(
  input wire clk,
  input wire nrst,
  input wire [7:0] pin_oe,
  input wire cfg_valid,
  input wire [1:0] cfg_an_en,
  input wire [1:0] cfg_speed100,
  input wire [1:0] an_ok,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire host_irq_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  oe_valid_a: assert property (pin_oe != 8'h00 |-> $past(cfg_valid))
    else $error("pins driven early");
  oe_whole_a: assert property (pin_oe == 8'h00 || pin_oe == 8'hFF)
    else $error("partial enable");
  valid_hold_a: assert property (cfg_valid |=> cfg_valid)
    else $error("valid dropped");
  one_wait_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  idle_wait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("idle wait");
  unmap_rd_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h10
    |-> avs_readdata == 32'h0) else $error("unmapped data");
  an_fail_a: assert property (cfg_valid && cfg_an_en[1] && !an_ok[1]
    |=> !cfg_speed100[1]) else $error("fail speed");
  irq_valid_a: assert property (!host_irq_n |-> cfg_valid)
    else $error("irq early");
endmodule
bind pscfg_top pscfg_chk i_chk
(
  .clk(clk), .nrst(nrst), .pin_oe(pin_oe), .cfg_valid(cfg_valid), .cfg_an_en(cfg_an_en),
  .cfg_speed100(cfg_speed100), .an_ok(an_ok), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .host_irq_n(host_irq_n)
);

// file: verification/tb.sv
/* self-checking bench for pscfg_top.
   assumes the board model holds straps through reset. */
`timescale 1ns/10ps
module tb;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wd = 32'h0;
  reg [31:0] q;
  reg [7:0] strap = 8'h00;
  reg [1:0] ok = 2'h0;
  reg [1:0] done = 2'h3;
  reg [1:0] link = 2'h3;
  reg [31:0] pats = 32'h5AA5FF00;
  wire [31:0] rdata;
  wire wrq, irq_n, irq_s, cv;
  wire [7:0] pad, pout, poe;
  wire [1:0] ca, cs, cf, cc;
  integer miscompares = 0;
  integer cmp_count = 0;
  integer i, k;
  always #12.5 clk = ~clk;
  pscfg_board i_board
  (
    .strap(strap), .pin_out(pout), .pin_oe(poe), .host_irq_n(irq_n), .pad(pad),
    .irq_seen_n(irq_s)
  );
  pscfg_top i_dut
  (
    .clk(clk), .nrst(nrst), .ce(1'b1), .port3_rx_valid_in(pad[0]),
    .port3_rx_bit3_in(pad[1]), .port3_rx_bit2_in(pad[2]), .port3_rx_bit1_in(pad[3]),
    .port3_rx_bit0_in(pad[4]), .serial_data_in_pin(pad[5]), .port1_led_a_in(pad[6]),
    .port1_led_b_in(pad[7]), .func_pin_out(8'h3C), .pin_out(pout), .pin_oe(poe),
    .an_done(done), .an_ok(ok), .an_speed100(2'h1), .an_full(2'h2), .an_pause(2'h1),
    .link_up(link), .cfg_an_en(ca), .cfg_speed100(cs), .cfg_full(cf), .cfg_fc_en(cc),
    .cfg_valid(cv), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wrq), .host_irq_n(irq_n)
  );
  task report_and_stop;
  begin
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error %0s exp %h seen %h", nm, exp, seen);
    end
  end
  endtask
  // request starts an edge after the last release, so no double drive
  task bus(input w, input [7:0] a, input [31:0] d);
  begin
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    while (wrq !== 1'b0)
      @(posedge clk);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  end
  endtask
  function [3:0] ecfg(input a, sp, dx, fc, g, s1, fl, pz);
  begin
    ecfg = {fc | (a & g & pz), (a & g) ? fl : dx, a ? (g & s1) : sp, a};
  end
  endfunction
  initial
  begin
    #400000;
    miscompares = miscompares + 1;
    report_and_stop;
  end
  initial
  begin
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clk);
      nrst <= 1'b0;
      strap <= pats[8*i+:8];
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (6) @(posedge clk);
      bus(1'b0, 8'h00, 32'h0);
      check("strap", q, {23'h0, 1'b1, strap});
      check("pins", {poe, pout}, 16'hFF3C);
      for (k = 0; k < 4; k = k + 1)
      begin
        // ok without done, or done without ok, must both count as a failed negotiation
        ok <= k[1:0];
        done <= {k[0], k[1]};
        repeat (3) @(posedge clk);
        check("p1", {cc[0], cf[0], cs[0], ca[0]}, ecfg(strap[6], strap[7], strap[0],
          strap[5], k[0] & k[1], 1'b1, 1'b0, 1'b1));
        check("p2", {cc[1], cf[1], cs[1], ca[1]}, ecfg(strap[1], strap[2], strap[3],
          strap[4], k[0] & k[1], 1'b0, 1'b1, 1'b0));
      end
    end
    bus(1'b1, 8'hBC, 32'h3);
    link <= 2'b01;
    repeat (3) @(posedge clk);
    check("irq", irq_s, 1'b0);
    bus(1'b0, 8'hBB, 32'h0);
    check("stat", q, 32'h2);
    bus(1'b1, 8'hBB, 32'h2);
    bus(1'b1, 8'hBC, 32'h1);
    link <= 2'b11;
    @(posedge clk);
    link <= 2'b01;
    repeat (3) @(posedge clk);
    check("masked", irq_s, 1'b1);
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    check("unmap", q, 32'h0);
    report_and_stop;
  end
endmodule
